//--- verilog/console_pkg.sv
package console_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int WORD_W    = 16;
   localparam int FLOC_W    = 15;
   localparam int TALLY_W   = 4;
   localparam int GPR_W     = 3;
   localparam int WB_ADR_W  = 4;
   localparam int WB_DAT_W  = 32;
   localparam int SEL_W     = 4;

   // ----------------------------------------------------------------
   // Wishbone byte addresses (word aligned)
   // ----------------------------------------------------------------
   localparam logic [WB_ADR_W-1:0] ADDR_SWITCHES = 4'h0;
   localparam logic [WB_ADR_W-1:0] ADDR_DISPLAY  = 4'h4;
   localparam logic [WB_ADR_W-1:0] ADDR_STATE    = 4'h8;

   // ----------------------------------------------------------------
   // Panel state word fields, read at ADDR_STATE
   // ----------------------------------------------------------------
   localparam int ST_RUN_MODE = 0;
   localparam int ST_UNLOCKED = 1;
   localparam int ST_RUNNING  = 2;
   localparam int ST_STEPPING = 3;
   localparam int ST_WAITING  = 4;
   localparam int ST_SEL_LSB  = 8;
   localparam int ST_SEL_W    = 3;
   localparam int ST_GPR_LSB  = 12;

   // ----------------------------------------------------------------
   // Status word layout on the display
   // ----------------------------------------------------------------
   localparam int STS_TALLY_LSB = 0;
   localparam int STS_LINK      = 4;
   localparam int STS_OVERFLOW  = 5;
   localparam int STS_PLUS      = 6;
   localparam int STS_ZERO      = 7;
   localparam int STS_FORE      = 8;
   localparam int FLOC_IE_BIT   = 15;

   // ----------------------------------------------------------------
   // Positions inside the synchronised switch vector
   // ----------------------------------------------------------------
   localparam int SW_DATA_LSB = 0;
   localparam int SW_GPR_LSB  = 16;
   localparam int SW_STATUS   = 19;
   localparam int SW_FLOC     = 20;
   localparam int SW_OPADDR   = 21;
   localparam int SW_HELD     = 22;
   localparam int SW_SAVEHELD = 23;
   localparam int SW_IDLE     = 24;
   localparam int SW_KEY      = 25;
   localparam int SW_BTN_LSB  = 26;
   localparam int SW_W        = 30;

   // Momentary button order inside the button group.
   localparam int BTN_ENTER  = 0;
   localparam int BTN_STEP   = 1;
   localparam int BTN_SYSRST = 2;
   localparam int BTN_CONINT = 3;
   localparam int BTN_N      = 4;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SEL_GPR,
      SEL_STATUS,
      SEL_FLOC,
      SEL_OPADDR,
      SEL_HELD
   } sel_t;

   typedef enum logic [1:0] {
      SEQ_HALT,
      SEQ_SINGLE,
      SEQ_RUN,
      SEQ_DRAIN
   } seq_t;

endpackage

//--- verilog/front_panel_console_control.sv
// Function
// - Display register loads from program in RUN, from selected register in IDLE.
// - Select switches prioritised; held-word switch overrides all others.
// - General register chosen by 3-bit code when other selects are off.
// - Status view: tally, link, overflow, plus, zero, foreground; writable.
// - Location counter view puts interrupt enable in bit 15; write keeps it.
// - Manual stop lets running instruction finish before halting.
// - Operand address latch is displayable and writable from data switches.
// - Program can read data switches; down reads one, up reads zero.
// - ENTER in IDLE overwrites the selected register with data switches.
// - STEP in IDLE executes one instruction cycle and advances counter.
// - Repeat-held-word in IDLE re-executes held word; no effect outside IDLE.
// - STEP in RUN starts continuous execution.
// - RUN/IDLE switch: up selects RUN, down selects IDLE.
// - Systems reset initialises core, disables interrupts, sets foreground.
// - With key lock disabled no console switch has any effect except on program reads.
// - Program reads of data switches ignore the key lock.
// - Console interrupt switch raises a request only when unlocked.
// - Foreground lamp lit for foreground, always dark without the option.
// - Lamps for ROM access, DMA steal, monitor alarm, interrupt enable.
// - Interrupt acknowledge lamp lit while serviced; exit by STEP or reset.
// - IDLE and RUN lamps follow mode; both lit at WAIT while running.
`timescale 1ns/1ps
`default_nettype none

module front_panel_console_control (
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   // Operator panel, asynchronous levels.
   input  wire logic [15:0] dataSw,
   input  wire logic [2:0]  gprSelSw,
   input  wire logic        statusSelSw,
   input  wire logic        flocSelSw,
   input  wire logic        opAddrSelSw,
   input  wire logic        heldSelSw,
   input  wire logic        repeatHeldSw,
   input  wire logic        idleSw,
   input  wire logic        keyEnableSw,
   input  wire logic        enterSw,
   input  wire logic        stepSw,
   input  wire logic        sysResetSw,
   input  wire logic        consoleIntSw,
   // Processor core, same clock.
   input  wire logic [15:0] coreGprData,
   input  wire logic [14:0] coreFetchLoc,
   input  wire logic        coreIntEnable,
   input  wire logic [15:0] coreOperandAddr,
   input  wire logic [15:0] coreHeldWord,
   input  wire logic [3:0]  coreRotTally,
   input  wire logic        coreLink,
   input  wire logic        coreOverflow,
   input  wire logic        corePlus,
   input  wire logic        coreZero,
   input  wire logic        coreForeground,
   input  wire logic        fgBgPresent,
   input  wire logic        coreRomAccess,
   input  wire logic        coreDmaSteal,
   input  wire logic        coreMonitorAlarm,
   input  wire logic        coreIntAck,
   input  wire logic        coreWaiting,
   input  wire logic        coreInstrDone,
   // Requests to the core.
   output logic [2:0]       gprIndex,
   output logic             regWrite,
   output logic [2:0]       regWriteSel,
   output logic [15:0]      regWriteData,
   output logic             stepReq,
   output logic             stepRepeatHeld,
   output logic             runReq,
   output logic             sysResetReq,
   output logic             consoleIntReq,
   // Lamps.
   output logic [15:0]      displayLamps,
   output logic             foregroundLamp,
   output logic             romLamp,
   output logic             dmaLamp,
   output logic             alarmLamp,
   output logic             intEnableLamp,
   output logic             intAckLamp,
   output logic             idleLamp,
   output logic             runLamp,
   // Classic Wishbone slave.
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o
);

   // ----------------
   // Selection decode
   // ----------------

   // Left-to-right priority: held word, operand address, counter, status.
   function automatic console_pkg::sel_t decodeSel(input logic [console_pkg::SW_W-1:0] sw);
      if (sw[console_pkg::SW_HELD]) begin
         return console_pkg::SEL_HELD;
      end else if (sw[console_pkg::SW_OPADDR]) begin
         return console_pkg::SEL_OPADDR;
      end else if (sw[console_pkg::SW_FLOC]) begin
         return console_pkg::SEL_FLOC;
      end else if (sw[console_pkg::SW_STATUS]) begin
         return console_pkg::SEL_STATUS;
      end else begin
         return console_pkg::SEL_GPR;
      end
   endfunction

   // ----------------
   // Switch synchronisers
   // ----------------

   logic [console_pkg::SW_W-1:0]  swRaw;
   logic [console_pkg::SW_W-1:0]  swMeta_q;
   logic [console_pkg::SW_W-1:0]  sw_q;
   logic [console_pkg::BTN_N-1:0] btnPrev_q;
   logic [console_pkg::BTN_N-1:0] btnPrev_d;
   logic [console_pkg::BTN_N-1:0] btnNow;
   logic [console_pkg::BTN_N-1:0] press;
   logic                          unlocked;

   // All panel inputs gathered into one vector.
   assign swRaw = {consoleIntSw, sysResetSw, stepSw, enterSw, keyEnableSw, idleSw, repeatHeldSw,
                   heldSelSw, opAddrSelSw, flocSelSw, statusSelSw, gprSelSw, dataSw};

   // Button edges are only honoured while the key lock enables the panel.
   always_comb begin
      btnNow    = sw_q[console_pkg::SW_BTN_LSB +: console_pkg::BTN_N];
      btnPrev_d = btnNow;
      unlocked  = sw_q[console_pkg::SW_KEY];
      press     = btnNow & ~btnPrev_q & {console_pkg::BTN_N{unlocked}};
   end

   // Two-stage synchroniser followed by the edge history register.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         swMeta_q  <= '0;
         sw_q      <= '0;
         btnPrev_q <= '0;
      end else begin
         swMeta_q  <= swRaw;
         sw_q      <= swMeta_q;
         btnPrev_q <= btnPrev_d;
      end
   end

   // ----------------
   // Panel settings, frozen while locked
   // ----------------

   logic                           runMode_q;
   logic                           runMode_d;
   console_pkg::sel_t              sel_q;
   console_pkg::sel_t              sel_d;
   logic [console_pkg::GPR_W-1:0]  gpr_q;
   logic [console_pkg::GPR_W-1:0]  gpr_d;
   logic                           saveHeld_q;
   logic                           saveHeld_d;

   // Level switches take effect only while the panel is unlocked.
   always_comb begin
      runMode_d  = runMode_q;
      sel_d      = sel_q;
      gpr_d      = gpr_q;
      saveHeld_d = saveHeld_q;
      if (unlocked) begin
         runMode_d  = ~sw_q[console_pkg::SW_IDLE];
         sel_d      = decodeSel(sw_q);
         gpr_d      = sw_q[console_pkg::SW_GPR_LSB +: console_pkg::GPR_W];
         saveHeld_d = sw_q[console_pkg::SW_SAVEHELD];
      end
   end

   // Settings start in IDLE with general register A selected.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         runMode_q  <= 1'b0;
         sel_q      <= console_pkg::SEL_GPR;
         gpr_q      <= '0;
         saveHeld_q <= 1'b0;
      end else begin
         runMode_q  <= runMode_d;
         sel_q      <= sel_d;
         gpr_q      <= gpr_d;
         saveHeld_q <= saveHeld_d;
      end
   end

   // ----------------
   // Execution sequencer
   // ----------------

   console_pkg::seq_t seq_q;
   console_pkg::seq_t seq_d;
   logic              stepReq_d;
   logic              repeat_d;
   logic              runReq_d;
   logic              sysRst_d;
   logic              conInt_d;
   logic              regWrite_d;
   logic [2:0]        regWriteSel_d;
   logic [15:0]       regWriteData_d;

   // Steps, runs, drains and panel writes toward the core.
   always_comb begin
      seq_d          = seq_q;
      stepReq_d      = 1'b0;
      repeat_d       = stepRepeatHeld;
      runReq_d       = runReq;
      sysRst_d       = press[console_pkg::BTN_SYSRST];
      conInt_d       = press[console_pkg::BTN_CONINT];
      regWrite_d     = 1'b0;
      regWriteSel_d  = sel_q;
      regWriteData_d = sw_q[console_pkg::SW_DATA_LSB +: console_pkg::WORD_W];
      if (press[console_pkg::BTN_SYSRST]) begin
         seq_d    = console_pkg::SEQ_HALT;
         runReq_d = 1'b0;
         repeat_d = 1'b0;
      end else begin
         unique case (seq_q)
            console_pkg::SEQ_HALT: begin
               if (press[console_pkg::BTN_STEP] && runMode_q) begin
                  seq_d    = console_pkg::SEQ_RUN;
                  runReq_d = 1'b1;
               end else if (press[console_pkg::BTN_STEP]) begin
                  seq_d     = console_pkg::SEQ_SINGLE;
                  stepReq_d = 1'b1;
                  repeat_d  = saveHeld_q;
               end else if (press[console_pkg::BTN_ENTER] && !runMode_q) begin
                  regWrite_d = 1'b1;
               end
            end
            console_pkg::SEQ_SINGLE: begin
               if (coreInstrDone) begin
                  seq_d    = console_pkg::SEQ_HALT;
                  repeat_d = 1'b0;
               end
            end
            console_pkg::SEQ_RUN: begin
               if (!runMode_q) begin
                  seq_d    = console_pkg::SEQ_DRAIN;
                  runReq_d = 1'b0;
               end
            end
            console_pkg::SEQ_DRAIN: begin
               if (coreInstrDone || coreWaiting) begin
                  seq_d = console_pkg::SEQ_HALT;
               end
            end
         endcase
      end
   end

   // Sequencer and core request registers.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         seq_q          <= console_pkg::SEQ_HALT;
         stepReq        <= 1'b0;
         stepRepeatHeld <= 1'b0;
         runReq         <= 1'b0;
         sysResetReq    <= 1'b0;
         consoleIntReq  <= 1'b0;
         regWrite       <= 1'b0;
         regWriteSel    <= '0;
         regWriteData   <= '0;
         gprIndex       <= '0;
      end else begin
         seq_q          <= seq_d;
         stepReq        <= stepReq_d;
         stepRepeatHeld <= repeat_d;
         runReq         <= runReq_d;
         sysResetReq    <= sysRst_d;
         consoleIntReq  <= conInt_d;
         regWrite       <= regWrite_d;
         regWriteSel    <= regWriteSel_d;
         regWriteData   <= regWriteData_d;
         gprIndex       <= gpr_d;
      end
   end

   // ----------------
   // Display register and lamps
   // ----------------

   logic [15:0] selValue;
   logic [15:0] display_d;
   logic        dispWrite;
   logic        foreground;

   // Foreground is meaningful only when the register-set option exists.
   assign foreground = fgBgPresent & coreForeground;

   // Picks the word that the current selection shows.
   always_comb begin
      selValue = '0;
      unique case (sel_q)
         console_pkg::SEL_GPR:    selValue = coreGprData;
         console_pkg::SEL_STATUS: begin
            selValue[console_pkg::STS_TALLY_LSB +: console_pkg::TALLY_W] = coreRotTally;
            selValue[console_pkg::STS_LINK]     = coreLink;
            selValue[console_pkg::STS_OVERFLOW] = coreOverflow;
            selValue[console_pkg::STS_PLUS]     = corePlus;
            selValue[console_pkg::STS_ZERO]     = coreZero;
            selValue[console_pkg::STS_FORE]     = foreground;
         end
         console_pkg::SEL_FLOC:   selValue = {coreIntEnable, coreFetchLoc};
         console_pkg::SEL_OPADDR: selValue = coreOperandAddr;
         console_pkg::SEL_HELD:   selValue = coreHeldWord;
         default:                 selValue = '0;
      endcase
   end

   // In IDLE the display tracks the selection; in RUN only the program writes it.
   always_comb begin
      display_d = displayLamps;
      if (!runMode_q) begin
         display_d = selValue;
      end else if (dispWrite) begin
         if (wb_sel_i[0]) begin
            display_d[7:0] = wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            display_d[15:8] = wb_dat_i[15:8];
         end
      end
   end

   // Lamp registers.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         displayLamps   <= '0;
         foregroundLamp <= 1'b0;
         romLamp        <= 1'b0;
         dmaLamp        <= 1'b0;
         alarmLamp      <= 1'b0;
         intEnableLamp  <= 1'b0;
         intAckLamp     <= 1'b0;
         idleLamp       <= 1'b0;
         runLamp        <= 1'b0;
      end else begin
         displayLamps   <= display_d;
         foregroundLamp <= foreground;
         romLamp        <= coreRomAccess;
         dmaLamp        <= coreDmaSteal;
         alarmLamp      <= coreMonitorAlarm;
         intEnableLamp  <= coreIntEnable;
         intAckLamp     <= coreIntAck;
         idleLamp       <= ~runMode_q | coreWaiting;
         runLamp        <= runMode_q;
      end
   end

   // ----------------
   // Wishbone slave
   // ----------------

   logic        ack_d;
   logic [31:0] rdData_d;
   logic [31:0] stateWord;

   // The write lands at the edge where the master samples the acknowledge.
   assign dispWrite = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & (wb_adr_i == console_pkg::ADDR_DISPLAY);

   // Panel state as seen by software.
   always_comb begin
      stateWord = '0;
      stateWord[console_pkg::ST_RUN_MODE] = runMode_q;
      stateWord[console_pkg::ST_UNLOCKED] = unlocked;
      stateWord[console_pkg::ST_RUNNING]  = runReq;
      stateWord[console_pkg::ST_STEPPING] = (seq_q == console_pkg::SEQ_SINGLE);
      stateWord[console_pkg::ST_WAITING]  = coreWaiting;
      stateWord[console_pkg::ST_SEL_LSB +: console_pkg::ST_SEL_W] = sel_q;
      stateWord[console_pkg::ST_GPR_LSB +: console_pkg::GPR_W]    = gpr_q;
   end

   // One-cycle acknowledge, then a gap; unmapped reads return zero.
   always_comb begin
      ack_d    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
      rdData_d = '0;
      if (ack_d && !wb_we_i) begin
         unique case (wb_adr_i)
            console_pkg::ADDR_SWITCHES: rdData_d = {16'h0000, sw_q[15:0]};
            console_pkg::ADDR_DISPLAY:  rdData_d = {16'h0000, displayLamps};
            console_pkg::ADDR_STATE:    rdData_d = stateWord;
            default:                    rdData_d = '0;
         endcase
      end
   end

   // Bus answer registers.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= ack_d;
         wb_dat_o <= rdData_d;
      end
   end

endmodule

`default_nettype wire

//--- test/console_checker_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module console_checker (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic keyEnableSw,
   input wire logic coreRomAccess,
   input wire logic coreDmaSteal,
   input wire logic coreMonitorAlarm,
   input wire logic coreIntEnable,
   input wire logic coreIntAck,
   input wire logic coreForeground,
   input wire logic fgBgPresent,
   input wire logic coreWaiting,
   input wire logic stepReq,
   input wire logic consoleIntReq,
   input wire logic sysResetReq,
   input wire logic foregroundLamp,
   input wire logic romLamp,
   input wire logic dmaLamp,
   input wire logic alarmLamp,
   input wire logic intEnableLamp,
   input wire logic intAckLamp,
   input wire logic idleLamp
);
   logic [1:0] upQ;
   // Counts edges after reset, since lamps are forced dark just after release.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         upQ <= 2'h0;
      end else if (upQ != 2'h3) begin
         upQ <= upQ + 2'h1;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   lamps_follow_a: assert property (upQ == 2'h3 |->
      {romLamp, dmaLamp, alarmLamp, intEnableLamp} == $past({coreRomAccess, coreDmaSteal, coreMonitorAlarm, coreIntEnable}))
      else $error("status lamps do not follow the core");
   ack_lamp_a: assert property (upQ == 2'h3 |-> intAckLamp == $past(coreIntAck))
      else $error("acknowledge lamp does not follow the core");
   fg_lamp_a: assert property (upQ == 2'h3 |-> foregroundLamp == $past(coreForeground & fgBgPresent))
      else $error("foreground lamp wrong");
   wait_lamp_a: assert property (upQ == 2'h3 && $past(coreWaiting) |-> idleLamp)
      else $error("idle lamp dark while the core waits");
   int_gate_a: assert property (consoleIntReq |-> $past(keyEnableSw, 3))
      else $error("console interrupt raised while locked");
   reset_gate_a: assert property (sysResetReq |-> $past(keyEnableSw, 3))
      else $error("system reset raised while locked");
   int_once_a: assert property (consoleIntReq |=> !consoleIntReq [*4])
      else $error("console interrupt request repeated");
   step_once_a: assert property (stepReq |=> !stepReq [*4])
      else $error("step request repeated");
endmodule
`default_nettype wire

//--- test/core_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_model (
   input wire logic         ref_clk,
   input wire logic         nrst,
   input wire logic [2:0]   gprIndex,
   input wire logic         regWrite,
   input wire logic [2:0]   regWriteSel,
   input wire logic [15:0]  regWriteData,
   input wire logic         stepReq,
   input wire logic         stepRepeatHeld,
   input wire logic         runReq,
   input wire logic         sysResetReq,
   input wire logic         waitCmd,
   output logic [15:0]      coreGprData,
   output logic [14:0]      coreFetchLoc,
   output logic             coreIntEnable,
   output logic [15:0]      coreOperandAddr,
   output logic [15:0]      coreHeldWord,
   output logic [8:0]       coreStatus,
   output logic [3:0]       coreLamps,
   output logic             coreWaiting,
   output logic             coreInstrDone
);
   logic [15:0] gpr [8];
   logic [1:0]  busyQ;
   // The addressed register and the wait state are plain levels.
   assign coreGprData = gpr[gprIndex];
   assign coreWaiting = waitCmd;
   // An instruction lasts three cycles; counter moves as it ends, and held word too unless repeating.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < 8; i++) gpr[i] <= 16'h0000;
         coreFetchLoc <= 15'h0000;
         coreIntEnable <= 1'b1;
         coreOperandAddr <= 16'h0000;
         coreHeldWord <= 16'h0000;
         coreStatus <= 9'h000;
         coreLamps <= 4'h0;
         coreInstrDone <= 1'b0;
         busyQ <= 2'h0;
      end else begin
         coreLamps <= coreLamps + 4'h1;
         coreInstrDone <= busyQ == 2'h1;
         if (busyQ != 2'h0) busyQ <= busyQ - 2'h1;
         if (busyQ == 2'h1) begin
            coreFetchLoc <= coreFetchLoc + 15'h0001;
            if (!stepRepeatHeld) coreHeldWord <= coreHeldWord ^ 16'h0101;
         end
         if (busyQ == 2'h0 && (stepReq || (runReq && !waitCmd))) busyQ <= 2'h3;
         if (regWrite) begin
            case (regWriteSel)
               3'h0: gpr[gprIndex] <= regWriteData;
               3'h1: coreStatus <= regWriteData[8:0];
               3'h2: coreFetchLoc <= regWriteData[14:0];
               3'h3: coreOperandAddr <= regWriteData;
               3'h4: coreHeldWord <= regWriteData;
               default: ;
            endcase
         end
         if (sysResetReq) begin
            coreIntEnable <= 1'b0;
            coreStatus[8] <= 1'b1;
            busyQ <= 2'h0;
         end
      end
   end
endmodule
`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic ref_clk, nrst, statusSelSw, flocSelSw, opAddrSelSw, heldSelSw, repeatHeldSw, idleSw, keyEnableSw;
   logic enterSw, stepSw, sysResetSw, consoleIntSw, fgBgPresent, waitCmd, wb_cyc_i, wb_stb_i, wb_we_i;
   logic coreIntEnable, coreLink, coreOverflow, corePlus, coreZero, coreForeground, coreWaiting, coreInstrDone;
   logic coreRomAccess, coreDmaSteal, coreMonitorAlarm, coreIntAck, regWrite, stepReq, stepRepeatHeld, runReq;
   logic sysResetReq, consoleIntReq, foregroundLamp, romLamp, dmaLamp, alarmLamp, intEnableLamp, intAckLamp;
   logic idleLamp, runLamp, wb_ack_o;
   logic [15:0] dataSw, coreGprData, coreOperandAddr, coreHeldWord, regWriteData, displayLamps;
   logic [14:0] coreFetchLoc;
   logic [8:0]  coreStatus;
   logic [3:0]  coreRotTally, coreLamps, btn, wb_adr_i, wb_sel_i;
   logic [2:0]  gprSelSw, gprIndex, regWriteSel;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   int          mismatches = 0, cmp_count = 0, cycles = 0, intCnt = 0;
   typedef struct packed {
      logic [6:0]  sel; // held, operand, location, status, general code
      logic        enter;
      logic [15:0] data;
      logic [15:0] want;
   } row_t;
   row_t rows [8] = '{'{7'h00, 1'b1, 16'hA5C3, 16'hA5C3}, '{7'h07, 1'b1, 16'h1234, 16'h1234},
      '{7'h08, 1'b1, 16'h00FF, 16'h00FF}, '{7'h10, 1'b1, 16'h7FFE, 16'hFFFE}, '{7'h20, 1'b1, 16'h8001, 16'h8001},
      '{7'h4F, 1'b1, 16'h0F0F, 16'h0F0F}, '{7'h07, 1'b0, 16'h0000, 16'h1234}, '{7'h00, 1'b0, 16'h0000, 16'hA5C3}};
   // Core status and lamp sources are split out of the model's packed words.
   assign {coreForeground, coreZero, corePlus, coreOverflow, coreLink, coreRotTally} = coreStatus;
   assign {coreIntAck, coreMonitorAlarm, coreDmaSteal, coreRomAccess} = coreLamps;
   assign {consoleIntSw, sysResetSw, stepSw, enterSw} = btn;
   front_panel_console_control dut (.*);
   core_model partner (.*);
   // Clock, press counter and run limit.
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      if (consoleIntReq === 1'b1) intCnt++;
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         conclude();
      end
   end
   task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
      end
   endtask
   task automatic chkFlag(input logic got, input logic exp);
      chkWord({31'h0, got}, {31'h0, exp});
   endtask
   task automatic chkDisp(input logic [15:0] exp);
      chkWord({16'h0000, displayLamps}, {16'h0000, exp});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic press(input int b);
      btn[b] <= 1'b1;
      cyc(6);
      btn[b] <= 1'b0;
      cyc(6);
   endtask
   task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_sel_i <= 4'h3;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Main sequence: table of selections, then stepping, lock, run and reset.
   initial begin
      {ref_clk, nrst, statusSelSw, flocSelSw, opAddrSelSw, heldSelSw, repeatHeldSw, waitCmd} = 8'h00;
      {wb_cyc_i, wb_stb_i, wb_we_i, idleSw, keyEnableSw, fgBgPresent} = 6'h07;
      {btn, wb_adr_i, wb_sel_i, gprSelSw, dataSw, wb_dat_i} = '0;
      cyc(20);
      nrst <= 1'b1;
      cyc(6);
      chkFlag(idleLamp & !runLamp, 1'b1);
      foreach (rows[i]) begin
         {heldSelSw, opAddrSelSw, flocSelSw, statusSelSw, gprSelSw} <= rows[i].sel;
         dataSw <= rows[i].data;
         cyc(6);
         if (rows[i].enter) press(console_pkg::BTN_ENTER);
         chkDisp(rows[i].want);
      end
      $display("test select table done");
      heldSelSw <= 1'b1;
      cyc(6);
      press(console_pkg::BTN_STEP);
      chkDisp(16'h0E0E);
      repeatHeldSw <= 1'b1;
      cyc(6);
      press(console_pkg::BTN_STEP);
      chkDisp(16'h0E0E);
      {heldSelSw, flocSelSw} <= 2'h1;
      cyc(6);
      chkDisp(16'h8000);
      $display("test step done");
      keyEnableSw <= 1'b0;
      cyc(6);
      {flocSelSw, dataSw} <= 17'h05A5A;
      cyc(6);
      press(console_pkg::BTN_ENTER);
      press(console_pkg::BTN_CONINT);
      press(console_pkg::BTN_SYSRST);
      chkDisp(16'h8000);
      chkWord(intCnt, 32'h0);
      chkFlag(intEnableLamp, 1'b1);
      wb(1'b0, console_pkg::ADDR_SWITCHES, 32'h0);
      chkWord(rd, 32'h0000_5A5A);
      wb(1'b0, 4'hC, 32'h0);
      chkWord(rd, 32'h0);
      keyEnableSw <= 1'b1;
      cyc(6);
      chkDisp(16'hA5C3);
      press(console_pkg::BTN_CONINT);
      chkWord(intCnt, 32'h1);
      $display("test lock done");
      idleSw <= 1'b0;
      cyc(6);
      chkFlag(runLamp & !idleLamp, 1'b1);
      wb(1'b1, console_pkg::ADDR_DISPLAY, 32'h0000_BEEF);
      cyc(2);
      chkDisp(16'hBEEF);
      press(console_pkg::BTN_STEP);
      chkFlag(runReq, 1'b1);
      waitCmd <= 1'b1;
      cyc(4);
      chkFlag(idleLamp & runLamp, 1'b1);
      idleSw <= 1'b1;
      cyc(10);
      chkFlag(runReq | runLamp, 1'b0);
      waitCmd <= 1'b0;
      press(console_pkg::BTN_SYSRST);
      chkFlag(intEnableLamp, 1'b0);
      chkFlag(foregroundLamp, 1'b1);
      fgBgPresent <= 1'b0;
      cyc(3);
      chkFlag(foregroundLamp, 1'b0);
      nrst <= 1'b0;
      cyc(2);
      chkDisp(16'h0000);
      $display("test run and reset done");
      conclude();
   end
endmodule
bind front_panel_console_control console_checker chk (.*);
`default_nettype wire
